/* rtl/dmsi_defines.svh */
// Address map, bit positions, vectors and reset values of the data memory register bank
// Function
// [RL1] General-purpose bytes live at 40H..7FH, readable and writable.
// [RL2] Unassigned locations below 40H read back as 00H.
// [RL3] Accesses to 00H are redirected to the address held in the memory pointer.
// [RL4] Indirect access to 00H itself reads 00H and ignores writes.
// [RL5] Memory pointer stores seven bits; its bit 7 always reads 1.
// [RL6] Single-bit set and clear work on data memory bits, except dedicated ones.
// [RL7] Status writes leave watchdog expired and powerdown flags untouched.
// [RL8] Watchdog expired flag set by time-out, cleared by power-up, watchdog clear, halt.
// [RL9] Powerdown flag set by halt, cleared by power-up or watchdog clear.
// [RL10] Carry flag: addition carry or subtraction no-borrow; rotate-through-carry updates it.
// [RL11] Half carry flag: low nibble carry on add, no nibble borrow on subtract.
// [RL12] Zero flag set when arithmetic or logic result is zero.
// [RL13] Signed range flag set when carry into and out of MSB differ.
// [RL14] Status bits 6 and 7 always read zero.
// [RL15] Interrupt entry and calls save only the program counter, never status.
// [RL16] Servicing an interrupt clears global enable; new requests still set flags.
// [RL17] Software may nest by setting global enable plus the source enable.
// [RL18] No interrupt acknowledge while the return stack is full.
// [RL19] External falling edge sets external flag; service vectors to 04H, clearing flag and enable.
// [RL20] Every interrupt source can wake the device from halt.
// [RL21] Interrupt control bits 0..3: global, external, timer, converter enables.
// [RL22] Interrupt control bits 4..6: external, timer, converter request flags.
// [RL23] Priority: external first, then timer at 08H, then converter at 0CH.
// [RL24] Interrupt return sets global enable; plain return leaves it alone.
// [RL25] Request flags stay set until serviced or cleared by software.
// [RL26] Requests judged at an instruction boundary; one source per acknowledge cycle.
`ifndef DMSI_DEFINES_SVH
`define DMSI_DEFINES_SVH

`define DMSI_A_IND 7'h00
`define DMSI_A_MP 7'h01
`define DMSI_A_ACC 7'h05
`define DMSI_A_PCL 7'h06
`define DMSI_A_TABLE_POINTER 7'h07
`define DMSI_A_TABLE_HIGH_BYTE 7'h08
`define DMSI_A_STATUS 7'h0A
`define DMSI_A_INTERRUPT_CONTROL 7'h0B
`define DMSI_A_TMR 7'h0D
`define DMSI_A_TIMER_CONTROL 7'h0E
`define DMSI_A_PA 7'h12
`define DMSI_A_PAC 7'h13
`define DMSI_A_PB 7'h14
`define DMSI_A_PBC 7'h15
`define DMSI_A_PD 7'h18
`define DMSI_A_PDC 7'h19
`define DMSI_A_ADC_RESULT_HIGH 7'h21
`define DMSI_A_ADC_CONTROL 7'h22
`define DMSI_A_ADC_CLOCK_SELECT 7'h23
`define DMSI_A_GP_BASE 7'h40

`define DMSI_ST_PDF 4
`define DMSI_ST_TO 5
`define DMSI_IC_GIE 0
`define DMSI_IC_EN_LO 1
`define DMSI_IC_EN_HI 3
`define DMSI_IC_FL_LO 4
`define DMSI_IC_FL_HI 6

`define DMSI_VEC_EXT 8'h04
`define DMSI_VEC_TMR 8'h08
`define DMSI_VEC_ADC 8'h0C

`define DMSI_ZERO_BYTE 8'h00
`define DMSI_MP_TOP 1'b1

`endif

/* rtl/dmsi_pkg.sv */
// Types shared by the data memory register bank
`default_nettype none
package dmsi_pkg;

  // One core access: plain read/write or single-bit set/clear
  typedef struct packed {
    logic rd;
    logic wr;
    logic bset;
    logic bclr;
    logic [6:0] addr;
    logic [2:0] bitn;
    logic [7:0] data;
  } dmsi_mem_req_t;

  typedef enum logic [1:0] {
    DMSI_ALU_ADD = 2'h0,
    DMSI_ALU_SUB = 2'h1,
    DMSI_ALU_LOGIC = 2'h2,
    DMSI_ALU_ROTC = 2'h3
  } dmsi_alu_kind_t;

  // For LOGIC, b carries the result; for ROTC, cin carries the new carry
  typedef struct packed {
    logic valid;
    dmsi_alu_kind_t kind;
    logic [7:0] a;
    logic [7:0] b;
    logic cin;
  } dmsi_alu_req_t;

  // Flag values in status order (ov, z, ac, c) with per-flag write enables
  typedef struct packed {
    logic [3:0] we;
    logic [3:0] val;
  } dmsi_flag_upd_t;

  typedef enum logic [1:0] {
    DMSI_IRQ_ARM = 2'b01,
    DMSI_IRQ_ACK = 2'b10
  } dmsi_irq_state_t;

endpackage
`default_nettype wire

/* rtl/dmsi_alu_flags.sv */
// Arithmetic flag generation for the status register
`timescale 1ns/100ps
`default_nettype none
`include "dmsi_defines.svh"
module dmsi_alu_flags
  import dmsi_pkg::*;
(
  // Request from the core
  input wire dmsi_pkg::dmsi_alu_req_t alu_req,
  // Flag update toward status
  output dmsi_pkg::dmsi_flag_upd_t flag_upd
);
  logic [7:0] b_eff;
  logic [8:0] sum9;
  logic [4:0] sum_lo;
  logic [7:0] sum_7;
  logic [7:0] res;

  // Subtraction as a + ~b + cin, so carry out means no borrow
  always_comb begin
    b_eff = (alu_req.kind == DMSI_ALU_SUB) ? ~alu_req.b : alu_req.b;
    sum9 = {1'b0, alu_req.a} + {1'b0, b_eff} + {8'h00, alu_req.cin};
    sum_lo = {1'b0, alu_req.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, alu_req.cin};
    sum_7 = {1'b0, alu_req.a[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, alu_req.cin};
    res = (alu_req.kind == DMSI_ALU_LOGIC) ? alu_req.b : sum9[7:0];
    flag_upd.we = 4'h0;
    flag_upd.val[0] = sum9[8]; // RL10
    flag_upd.val[1] = sum_lo[4]; // RL11
    flag_upd.val[2] = (res == `DMSI_ZERO_BYTE); // RL12
    flag_upd.val[3] = sum_7[7] ^ sum9[8]; // RL13
    if (alu_req.valid) begin
      case (alu_req.kind)
        DMSI_ALU_ADD, DMSI_ALU_SUB: flag_upd.we = 4'hF;
        DMSI_ALU_LOGIC: flag_upd.we = 4'h4;
        DMSI_ALU_ROTC: begin
          flag_upd.we = 4'h1;
          flag_upd.val[0] = alu_req.cin; // RL10
        end
        default: flag_upd.we = 4'h0;
      endcase
    end
  end
endmodule
`default_nettype wire

/* rtl/dmsi_irq_arb.sv */
// Fixed-priority pick among pending enabled interrupt sources
`timescale 1ns/100ps
`default_nettype none
`include "dmsi_defines.svh"
module dmsi_irq_arb #(
  parameter int N_SRC = 3
) (
  // Pending and enabled sources, bit 0 highest priority
  input wire logic [N_SRC-1:0] pend,
  // Chosen source and its vector
  output logic [N_SRC-1:0] grant,
  output logic [7:0] vec
);
  function automatic logic [7:0] src_vec(input int idx);
    case (idx)
      0: src_vec = `DMSI_VEC_EXT;
      1: src_vec = `DMSI_VEC_TMR;
      default: src_vec = `DMSI_VEC_ADC;
    endcase
  endfunction

  always_comb begin
    grant = '0;
    vec = `DMSI_ZERO_BYTE;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        grant = '0;
        grant[i] = 1'b1; // RL23
        vec = src_vec(i); // RL23
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/dmsi_regbank.sv */
// Data memory, special function registers, status flags and interrupt control
`timescale 1ns/100ps
`default_nettype none
`include "dmsi_defines.svh"
module dmsi_regbank #(
  parameter int GP_DEPTH = 64,
  parameter int SFR_DEPTH = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Core data memory access
  input wire dmsi_pkg::dmsi_mem_req_t mem_req,
  output logic [7:0] rd_data,
  // Core flag update
  input wire dmsi_pkg::dmsi_alu_req_t alu_req,
  // Core operation strobes
  input wire logic wdt_timeout,
  input wire logic watchdog_clear_op,
  input wire logic halt_op,
  input wire logic irq_return_op,
  input wire logic instr_boundary,
  input wire logic stack_full,
  // Read-only values supplied by neighbouring blocks
  input wire logic [7:0] table_high_in,
  input wire logic [7:0] adc_result_in,
  // Interrupt sources
  input wire logic ext_int_n,
  input wire logic timer_ovf,
  input wire logic adc_eoc,
  // Interrupt handshake toward the core
  output logic irq_ack,
  output logic [7:0] irq_vector,
  output logic wake_req
);
  import dmsi_pkg::*;

  localparam int GP_AW = $clog2(GP_DEPTH);
  localparam int SFR_AW = $clog2(SFR_DEPTH);

  logic [7:0] gp_mem [0:GP_DEPTH-1];
  logic [7:0] sfr_mem [0:SFR_DEPTH-1];
  logic [6:0] memory_pointer;
  logic [3:0] arith_flags;
  logic watchdog_expired_flag;
  logic powerdown_flag;
  logic [3:0] irq_enables;
  logic [2:0] irq_flags;
  logic ext_int_q;
  dmsi_irq_state_t irq_state;

  logic ind_sel;
  logic [6:0] eff_addr;
  logic ind_null;
  logic [7:0] cur_val;
  logic [7:0] bit_mask;
  logic [7:0] wval;
  logic do_write;
  logic wr_status;
  logic wr_interrupt_control;
  logic ext_fall;
  logic [2:0] irq_pend;
  logic [2:0] irq_grant;
  logic [7:0] grant_vec;
  logic can_ack;
  logic [2:0] next_irq_flags;
  dmsi_flag_upd_t flag_upd;

  // Locations held in the generic register array
  function automatic logic sfr_impl(input logic [6:0] a);
    case (a)
      `DMSI_A_ACC, `DMSI_A_PCL, `DMSI_A_TABLE_POINTER, `DMSI_A_TMR, `DMSI_A_TIMER_CONTROL,
      `DMSI_A_PA, `DMSI_A_PAC, `DMSI_A_PB, `DMSI_A_PBC, `DMSI_A_PD,
      `DMSI_A_PDC, `DMSI_A_ADC_CONTROL, `DMSI_A_ADC_CLOCK_SELECT: sfr_impl = 1'b1;
      default: sfr_impl = 1'b0;
    endcase
  endfunction

  function automatic logic is_gp(input logic [6:0] a);
    is_gp = (a >= `DMSI_A_GP_BASE);
  endfunction

  dmsi_alu_flags u_flags (
    .alu_req(alu_req),
    .flag_upd(flag_upd)
  );

  dmsi_irq_arb #(
    .N_SRC(3)
  ) u_arb (
    .pend(irq_pend),
    .grant(irq_grant),
    .vec(grant_vec)
  );

  // Address resolution; the pointer never holds 00H meaningfully, so no chaining
  always_comb begin
    ind_sel = (mem_req.addr == `DMSI_A_IND);
    eff_addr = ind_sel ? memory_pointer : mem_req.addr; // RL3
    ind_null = ind_sel && (memory_pointer == `DMSI_A_IND); // RL4
  end

  // Current contents of the resolved location
  always_comb begin
    case (eff_addr)
      `DMSI_A_IND: cur_val = `DMSI_ZERO_BYTE; // RL4
      `DMSI_A_MP: cur_val = {`DMSI_MP_TOP, memory_pointer}; // RL5
      `DMSI_A_STATUS: cur_val = {2'b00, watchdog_expired_flag, powerdown_flag,
                                 arith_flags}; // RL14
      `DMSI_A_INTERRUPT_CONTROL: cur_val = {1'b0, irq_flags, irq_enables}; // RL21 RL22
      `DMSI_A_TABLE_HIGH_BYTE: cur_val = table_high_in;
      `DMSI_A_ADC_RESULT_HIGH: cur_val = adc_result_in;
      default: begin
        if (is_gp(eff_addr)) begin
          cur_val = gp_mem[eff_addr[GP_AW-1:0]]; // RL1
        end else if (sfr_impl(eff_addr)) begin
          cur_val = sfr_mem[eff_addr[SFR_AW-1:0]];
        end else begin
          cur_val = `DMSI_ZERO_BYTE; // RL2
        end
      end
    endcase
  end

  // Write value, with bit operations as read-modify-write of the same location
  always_comb begin
    bit_mask = 8'h01 << mem_req.bitn;
    if (mem_req.bset) begin
      wval = cur_val | bit_mask; // RL6
    end else if (mem_req.bclr) begin
      wval = cur_val & ~bit_mask; // RL6
    end else begin
      wval = mem_req.data;
    end
    do_write = (mem_req.wr || mem_req.bset || mem_req.bclr) && !ind_null; // RL4
    wr_status = do_write && (eff_addr == `DMSI_A_STATUS);
    wr_interrupt_control = do_write && (eff_addr == `DMSI_A_INTERRUPT_CONTROL);
  end

  // General-purpose memory is not cleared by reset, as on the real array
  always_ff @(posedge clk) begin
    if (do_write && is_gp(eff_addr)) begin
      gp_mem[eff_addr[GP_AW-1:0]] <= wval; // RL1
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < SFR_DEPTH; i++) begin
        sfr_mem[i] <= `DMSI_ZERO_BYTE;
      end
    end else if (do_write && sfr_impl(eff_addr)) begin
      sfr_mem[eff_addr[SFR_AW-1:0]] <= wval;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      memory_pointer <= 7'h00;
    end else if (do_write && eff_addr == `DMSI_A_MP) begin
      memory_pointer <= wval[6:0]; // RL5
    end
  end

  // Read data is registered and valid in the cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= `DMSI_ZERO_BYTE;
    end else if (mem_req.rd) begin
      rd_data <= cur_val;
    end else begin
      rd_data <= `DMSI_ZERO_BYTE;
    end
  end

  // A direct write wins over a flag update from the same instruction
  always_ff @(posedge clk) begin
    if (rst) begin
      arith_flags <= 4'h0;
    end else if (wr_status) begin
      arith_flags <= wval[3:0]; // RL7
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (flag_upd.we[i]) begin
          arith_flags[i] <= flag_upd.val[i]; // RL10 RL11 RL12 RL13
        end
      end
    end
  end

  // Time-out set wins over a same-cycle clear so the reset cause is not lost
  always_ff @(posedge clk) begin
    if (rst) begin
      watchdog_expired_flag <= 1'b0;
    end else if (wdt_timeout) begin
      watchdog_expired_flag <= 1'b1; // RL8
    end else if (watchdog_clear_op || halt_op) begin
      watchdog_expired_flag <= 1'b0; // RL8
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      powerdown_flag <= 1'b0;
    end else if (halt_op) begin
      powerdown_flag <= 1'b1; // RL9
    end else if (watchdog_clear_op) begin
      powerdown_flag <= 1'b0; // RL9
    end
  end

  // Input is synchronous; one stage is enough for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_int_q <= 1'b1;
    end else begin
      ext_int_q <= ext_int_n;
    end
  end

  always_comb begin
    ext_fall = ext_int_q && !ext_int_n; // RL19
    irq_pend = irq_flags & irq_enables[`DMSI_IC_EN_HI:`DMSI_IC_EN_LO];
    can_ack = instr_boundary && irq_enables[`DMSI_IC_GIE] && !stack_full
              && (|irq_pend) && (irq_state == DMSI_IRQ_ARM); // RL18 RL26
  end

  // Events set flags even while the global enable is off; set beats any clear
  always_comb begin
    next_irq_flags = wr_interrupt_control ? wval[`DMSI_IC_FL_HI:`DMSI_IC_FL_LO] : irq_flags; // RL25
    if (can_ack) begin
      next_irq_flags = next_irq_flags & ~irq_grant; // RL19
    end
    next_irq_flags = next_irq_flags | {adc_eoc, timer_ovf, ext_fall}; // RL16 RL22
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_flags <= 3'h0;
    end else begin
      irq_flags <= next_irq_flags;
    end
  end

  // Enables: service clears global enable, interrupt return sets it
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_enables <= 4'h0;
    end else begin
      if (wr_interrupt_control) begin
        irq_enables <= wval[`DMSI_IC_EN_HI:0]; // RL21
      end
      if (can_ack) begin
        irq_enables[`DMSI_IC_GIE] <= 1'b0; // RL16
      end else if (irq_return_op) begin
        irq_enables[`DMSI_IC_GIE] <= 1'b1; // RL24
      end
    end
  end

  // Acknowledge carries only the vector; status is never stacked here
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_state <= DMSI_IRQ_ARM;
    end else begin
      case (irq_state)
        DMSI_IRQ_ARM: begin
          if (can_ack) begin
            irq_state <= DMSI_IRQ_ACK; // RL26
          end
        end
        DMSI_IRQ_ACK: irq_state <= DMSI_IRQ_ARM;
        default: irq_state <= DMSI_IRQ_ARM;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_ack <= 1'b0;
      irq_vector <= `DMSI_ZERO_BYTE;
    end else begin
      irq_ack <= can_ack; // RL15
      if (can_ack) begin
        irq_vector <= grant_vec; // RL19 RL23
      end
    end
  end

  // Wake needs only the source enable; global enable matters after wake-up
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= powerdown_flag && (|irq_pend); // RL20
    end
  end

  sequence s_take;
    can_ack;
  endsequence

  sequence s_read_at(logic [6:0] a);
    mem_req.rd && (eff_addr == a);
  endsequence

  property p_mp_top;
    @(posedge clk) disable iff (rst)
      s_read_at(`DMSI_A_MP) |=> rd_data[7];
  endproperty
  a_mp_top: assert property (p_mp_top) else $error("pointer bit 7 read as 0"); // RL5

  property p_unimpl_zero;
    @(posedge clk) disable iff (rst)
      mem_req.rd && !is_gp(eff_addr) && !sfr_impl(eff_addr)
      && eff_addr != `DMSI_A_MP && eff_addr != `DMSI_A_STATUS
      && eff_addr != `DMSI_A_INTERRUPT_CONTROL && eff_addr != `DMSI_A_TABLE_HIGH_BYTE
      && eff_addr != `DMSI_A_ADC_RESULT_HIGH |=> rd_data == `DMSI_ZERO_BYTE;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unused address read nonzero"); // RL2

  property p_ind_ptr;
    @(posedge clk) disable iff (rst)
      mem_req.wr && ind_sel && is_gp(memory_pointer) ##1 s_read_at($past(memory_pointer))
      |=> rd_data == $past(mem_req.data, 2);
  endproperty
  a_ind_ptr: assert property (p_ind_ptr) else $error("indirect write missed target"); // RL3

  property p_ind_null;
    @(posedge clk) disable iff (rst)
      mem_req.rd && ind_null |=> rd_data == `DMSI_ZERO_BYTE;
  endproperty
  a_ind_null: assert property (p_ind_null) else $error("null indirect read nonzero"); // RL4

  property p_status_guard;
    @(posedge clk) disable iff (rst)
      wr_status && !wdt_timeout && !halt_op && !watchdog_clear_op
      |=> watchdog_expired_flag == $past(watchdog_expired_flag)
          && powerdown_flag == $past(powerdown_flag)
          && arith_flags == $past(wval[3:0]);
  endproperty
  a_status_guard: assert property (p_status_guard) else $error("status write hit guarded flag"); // RL7

  property p_halt;
    @(posedge clk) disable iff (rst)
      halt_op && !wdt_timeout |=> powerdown_flag && !watchdog_expired_flag;
  endproperty
  a_halt: assert property (p_halt) else $error("halt flags wrong"); // RL9

  property p_timeout;
    @(posedge clk) disable iff (rst)
      wdt_timeout |=> watchdog_expired_flag;
  endproperty
  a_timeout: assert property (p_timeout) else $error("time-out flag not set"); // RL8

  property p_status_high;
    @(posedge clk) disable iff (rst)
      s_read_at(`DMSI_A_STATUS) |=> rd_data[7:6] == 2'b00;
  endproperty
  a_status_high: assert property (p_status_high) else $error("status high bits set"); // RL14

  property p_service;
    @(posedge clk) disable iff (rst)
      s_take |=> irq_ack && !irq_enables[`DMSI_IC_GIE] ##1 !irq_ack;
  endproperty
  a_service: assert property (p_service) else $error("service did not mask or repeated"); // RL16

  property p_stack_hold;
    @(posedge clk) disable iff (rst)
      stack_full |=> !irq_ack;
  endproperty
  a_stack_hold: assert property (p_stack_hold) else $error("acknowledge with full stack"); // RL18

  property p_ext_first;
    @(posedge clk) disable iff (rst)
      s_take and irq_pend[0] |=> irq_vector == `DMSI_VEC_EXT && !irq_flags[0];
  endproperty
  a_ext_first: assert property (p_ext_first) else $error("external not served first"); // RL19

  property p_timer_next;
    @(posedge clk) disable iff (rst)
      s_take and (irq_pend[1:0] == 2'b10) |=> irq_vector == `DMSI_VEC_TMR;
  endproperty
  a_timer_next: assert property (p_timer_next) else $error("timer vector wrong"); // RL23

  property p_irq_return_op;
    @(posedge clk) disable iff (rst)
      irq_return_op && !can_ack |=> irq_enables[`DMSI_IC_GIE];
  endproperty
  a_irq_return_op: assert property (p_irq_return_op) else $error("return did not re-enable"); // RL24

  property p_flag_hold;
    @(posedge clk) disable iff (rst)
      irq_flags[2] && !can_ack && !wr_interrupt_control |=> irq_flags[2];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("request flag dropped"); // RL25

endmodule
`default_nettype wire

/* test/dmsi_periph_model.sv */
// Peripheral side model: external interrupt pin and request pulses on command
`timescale 1ns/100ps
`default_nettype none
module dmsi_periph_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Commands: bit 0 external, bit 1 timer, bit 2 converter
  input wire logic [2:0] fire,
  // Toward the bank
  output var logic ext_int_n,
  output var logic timer_ovf,
  output var logic adc_eoc
);
  logic [1:0] low_cnt = 2'h0;
  // Pin has a pull-up and idles high; held low two cycles so the falling edge is clean
  always @(posedge clk) begin
    if (rst) begin
      low_cnt <= 2'h0;
    end else if (fire[0]) begin
      low_cnt <= 2'h2;
    end else if (low_cnt != 2'h0) begin
      low_cnt <= low_cnt - 2'h1;
    end
  end
  always_comb ext_int_n = (low_cnt == 2'h0);
  initial timer_ovf = 1'b0;
  initial adc_eoc = 1'b0;
  always @(posedge clk) begin
    timer_ovf <= fire[1] & ~rst;
    adc_eoc <= fire[2] & ~rst;
  end
endmodule
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the data memory register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dmsi_pkg::*;
  `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp=%h got=%h", nm, e, g); end end
  logic clk = 1'b0;
  logic rst = 1'b1;
  dmsi_mem_req_t mem_req = '0;
  dmsi_alu_req_t alu_req = '0;
  logic [3:0] strb = 4'h0;
  logic [2:0] fire = 3'h0;
  logic instr_boundary = 1'b1;
  logic stack_full = 1'b1;
  logic [7:0] table_high_in = 8'h00;
  logic [7:0] adc_result_in = 8'h00;
  logic ext_int_n, timer_ovf, adc_eoc, irq_ack, wake_req;
  logic [7:0] rd_data, irq_vector, e_v, a8, b8;
  logic [6:0] ad;
  logic [1:0] k;
  logic c1;
  logic rd_d = 1'b0;
  logic [3:0] fl;
  logic [7:0] exp_rd[$];
  logic [7:0] exp_vec[$];
  int n_fail = 0;
  int n_compared = 0;
  int seed = 78098;

  initial forever #20 clk = ~clk;

  dmsi_periph_model u_dmsi_periph_model (.clk(clk), .rst(rst), .fire(fire),
    .ext_int_n(ext_int_n), .timer_ovf(timer_ovf), .adc_eoc(adc_eoc));
  dmsi_regbank u_dmsi_regbank (.clk(clk), .rst(rst), .mem_req(mem_req), .rd_data(rd_data),
    .alu_req(alu_req), .wdt_timeout(strb[0]), .watchdog_clear_op(strb[1]),
    .halt_op(strb[2]), .irq_return_op(strb[3]), .instr_boundary(instr_boundary),
    .stack_full(stack_full), .table_high_in(table_high_in), .adc_result_in(adc_result_in),
    .ext_int_n(ext_int_n), .timer_ovf(timer_ovf), .adc_eoc(adc_eoc), .irq_ack(irq_ack),
    .irq_vector(irq_vector), .wake_req(wake_req));

  // Every step drives all strobes once, so nothing is assigned twice at one edge
  task automatic step(input dmsi_mem_req_t m, input dmsi_alu_req_t a, input logic [3:0] s,
      input logic [2:0] f);
    mem_req <= m;
    alu_req <= a;
    strb <= s;
    fire <= f;
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    repeat (n) step('0, '0, 4'h0, 3'h0);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    step({4'b0100, a, 3'h0, d}, '0, 4'h0, 3'h0);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    step({4'b1000, a, 3'h0, 8'h00}, '0, 4'h0, 3'h0);
  endtask
  task automatic bit_op(input logic set, input logic [6:0] a, input logic [2:0] b);
    step({2'b00, set, ~set, a, b, 8'h00}, '0, 4'h0, 3'h0);
  endtask
  task automatic strobe(input logic [3:0] s);
    step('0, '0, s, 3'h0);
  endtask

  // Flags in status order: signed range, zero, half carry, carry
  function automatic logic [3:0] exp_flags(input logic [1:0] kd, input logic [7:0] a,
      input logic [7:0] b, input logic c, input logic [3:0] old);
    logic [7:0] bb;
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] l;
    bb = (kd == 2'h1) ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {8'h00, c};
    h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, c};
    l = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, c};
    case (kd)
      2'h2: return {old[3], b == 8'h00, old[1:0]};
      2'h3: return {old[3:1], c};
      default: return {l[7] ^ s[8], s[7:0] == 8'h00, h[4], s[8]};
    endcase
  endfunction

  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Result watcher: one note is consumed for each read answer and each acknowledge
  always @(posedge clk) rd_d <= mem_req.rd;
  always @(negedge clk) begin
    if (rd_d) begin
      e_v = exp_rd.pop_front();
      `CHK("rd_data", e_v, rd_data)
    end else if (!rst) begin
      `CHK("rd_idle", 8'h00, rd_data)
    end
    if (irq_ack === 1'b1) begin
      if (exp_vec.size() == 0) begin
        `CHK("irq_ack", 1'b0, irq_ack)
      end else begin
        e_v = exp_vec.pop_front();
        `CHK("irq_vector", e_v, irq_vector)
      end
    end
  end

  initial begin
    #(40 * 4000);
    n_fail++;
    $display("watchdog expired before the sequence ended");
    final_report();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(7'h0A, 8'h00);
    rd(7'h0B, 8'h00);
    rd(7'h01, 8'h80);
    wr(7'h30, 8'hA5);
    rd(7'h30, 8'h00);
    a8 = 8'($random(seed));
    b8 = 8'($random(seed));
    table_high_in <= a8;
    adc_result_in <= b8;
    wr(7'h08, ~a8);
    rd(7'h08, a8);
    rd(7'h21, b8);
    for (int i = 0; i < 16; i++) begin
      ad = {1'b1, (i < 2) ? {6{i[0]}} : 6'($random(seed))};
      a8 = 8'($random(seed));
      wr(ad, a8);
      rd(ad, a8);
    end
    wr(7'h01, 8'hFF);
    rd(7'h01, 8'hFF);
    wr(7'h01, 8'h45);
    rd(7'h01, 8'hC5);
    wr(7'h00, 8'hA5);
    rd(7'h45, 8'hA5);
    bit_op(1'b0, 7'h00, 3'h7);
    bit_op(1'b1, 7'h45, 3'h1);
    rd(7'h00, 8'h27);
    wr(7'h01, 8'h00);
    wr(7'h00, 8'h33);
    rd(7'h00, 8'h00);
    wr(7'h0A, 8'hFF);
    rd(7'h0A, 8'h0F);
    strobe(4'h4);
    rd(7'h0A, 8'h1F);
    strobe(4'h1);
    rd(7'h0A, 8'h3F);
    wr(7'h0A, 8'h00);
    rd(7'h0A, 8'h30);
    bit_op(1'b0, 7'h0A, 3'h5);
    bit_op(1'b1, 7'h0A, 3'h0);
    rd(7'h0A, 8'h31);
    strobe(4'h4);
    rd(7'h0A, 8'h11);
    strobe(4'h2);
    rd(7'h0A, 8'h01);
    fl = 4'h1;
    for (int i = 0; i < 24; i++) begin
      k = 2'(i);
      a8 = 8'($random(seed));
      b8 = i[3] ? 8'($random(seed)) : ((k == 2'h0) ? 8'(-a8) : ((k == 2'h1) ? a8 : 8'h00));
      c1 = (k == 2'h1) ? ~i[4] : i[2];
      fl = exp_flags(k, a8, b8, c1, fl);
      step('0, {1'b1, k, a8, b8, c1}, 4'h0, 3'h0);
      rd(7'h0A, {4'h0, fl});
    end
    // All three sources at once while the return stack is full
    wr(7'h0B, 8'h0F);
    step('0, '0, 4'h0, 3'h7);
    idle(4);
    rd(7'h0B, 8'h7F);
    exp_vec.push_back(8'h04);
    stack_full <= 1'b0;
    idle(4);
    rd(7'h0B, 8'h6E);
    exp_vec.push_back(8'h08);
    strobe(4'h8);
    idle(3);
    rd(7'h0B, 8'h4E);
    // No boundary, no acknowledge: an early one finds the queue empty
    instr_boundary <= 1'b0;
    wr(7'h0B, 8'h4F);
    idle(2);
    exp_vec.push_back(8'h0C);
    instr_boundary <= 1'b1;
    idle(3);
    rd(7'h0B, 8'h0E);
    wr(7'h0B, 8'h20);
    idle(3);
    rd(7'h0B, 8'h20);
    wr(7'h0B, 8'h04);
    rd(7'h0B, 8'h04);
    strobe(4'h4);
    step('0, '0, 4'h0, 3'h2);
    @(negedge clk);
    `CHK("wake_low", 1'b0, wake_req)
    @(posedge clk);
    idle(2);
    @(negedge clk);
    `CHK("wake_req", 1'b1, wake_req)
    @(posedge clk);
    rd(7'h0B, 8'h24);
    idle(3);
    `CHK("vec_left", 0, exp_vec.size())
    final_report();
  end
endmodule
`default_nettype wire
